//--- core/sssr_regs.sv
// sensor status, completion sync, configuration store and device clear
//
// How it works
// - status bit 1 follows sensor present on the first channel
// - status bit 2 follows sensor present on the second channel
// - bit 3 set on first channel memory fault or front and rear both used
// - bit 4 set on second channel memory fault or front and rear both used
// - bit 5 high when first channel sensor sits on rear connector
// - bit 6 high when second channel sensor sits on rear connector
// - key press sets event bit 14 only; cleared by reading the event register
// - completion query queues ASCII one once nothing is pending
// - completion command sets event bit 0 once nothing is pending
// - enabled events summarise into status byte bit 5; mask 32 raises request
// - event enable value 1 lets the completion bit reach the summary
// - clear status empties every event register
// - ten configuration slots, numbered 1 to 10, saved and recalled
// - saved configuration excludes errors, address, language, cal and zero
// - device clear leaves status, error queue and settings untouched
// - device clear aborts measuring, idles trigger, flushes buffers
`timescale 1ns/10ps
`default_nettype none
module sssr_regs
    import sssr_pkg::*;
#(
    parameter int CFG_W    = 32,
    parameter int SLOTS    = 10
) (
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    input  wire logic              ce_i,
    // sensor pins from the connectors, asynchronous
    input  wire logic              a_front_i,
    input  wire logic              a_rear_i,
    input  wire logic              b_front_i,
    input  wire logic              b_rear_i,
    input  wire logic              a_mem_fail_i,
    input  wire logic              b_mem_fail_i,
    input  wire logic              key_press_i,
    // command port from the decoder, same clock
    input  wire logic              op_valid_i,
    input  wire logic [3:0]        op_code_i,
    input  wire logic [7:0]        op_data_i,
    input  wire logic              pending_i,
    input  wire logic [CFG_W-1:0]  cfg_live_i,
    input  wire logic              reply_taken_i,
    input  wire logic              dev_clear_i,
    // status outputs
    output logic [15:0]            dev_status_o,
    output logic [15:0]            dev_event_o,
    output logic [7:0]             std_event_o,
    output logic [7:0]             status_byte_o,
    output logic                   srq_o,
    output logic [7:0]             reply_data_o,
    output logic                   reply_valid_o,
    output logic [CFG_W-1:0]       cfg_recall_o,
    output logic                   cfg_recall_vld_o,
    output logic                   slot_err_o,
    output logic                   abort_o
);
    // all outputs are registered, so downstream timing starts at a flop

    // three-stage synchronisers for the seven pin inputs; the first stage
    // may go metastable, so only the second stage ever reads it
    localparam int NPIN = 7;
    logic      [NPIN-1:0] pin_raw;
    wire logic [NPIN-1:0] pin_q;
    assign pin_raw = {key_press_i, b_mem_fail_i, a_mem_fail_i,
                      b_rear_i, b_front_i, a_rear_i, a_front_i};

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_sync
            // each pin owns its stages, so no vector has several writers
            logic sync1;
            logic sync2;
            logic sync3;
            logic level;
            // a level counts only once the second and third stages agree;
            // a glitch shorter than two clocks never reaches the registers
            always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    sync1 <= 1'b0;
                    sync2 <= 1'b0;
                    sync3 <= 1'b0;
                    level <= 1'b0;
                end else if (ce_i) begin
                    sync1 <= pin_raw[g];
                    sync2 <= sync1;
                    sync3 <= sync2;
                    if (sync2 == sync3) begin
                        level <= sync3;
                    end
                end
            end
            assign pin_q[g] = level;
        end
    endgenerate

    // pin order follows pin_raw above; bit 6 is the key
    wire a_fr  = pin_q[0];
    wire a_rr  = pin_q[1];
    wire b_fr  = pin_q[2];
    wire b_rr  = pin_q[3];
    wire a_mf  = pin_q[4];
    wire b_mf  = pin_q[5];
    wire key_q = pin_q[6];

    // one channel's error: memory fault or both connectors occupied
    function automatic logic chan_err(input logic mf, input logic f,
                                      input logic r);
        chan_err = mf | (f & r);
    endfunction

    // condition register, unused bits tied low
    // an empty channel reads 0 on its rear bit as well; only rear sets it
    logic [15:0] next_cond;
    always_comb begin
        next_cond = SSSR_RST_STAT;
        next_cond[SSSR_BIT_A_CONN] = a_fr | a_rr;
        next_cond[SSSR_BIT_B_CONN] = b_fr | b_rr;
        next_cond[SSSR_BIT_A_ERR]  = chan_err(a_mf, a_fr, a_rr);
        next_cond[SSSR_BIT_B_ERR]  = chan_err(b_mf, b_fr, b_rr);
        // rear alone reads 1; front reads 0
        next_cond[SSSR_BIT_A_REAR] = a_rr;
        next_cond[SSSR_BIT_B_REAR] = b_rr;
    end

    // command decode; one helper so every strobe qualifies the same way
    function automatic logic op_hit(input logic vld, input logic [3:0] code,
                                    input sssr_op_t op);
        op_hit = vld && code == 4'(op);
    endfunction
    wire op_cls  = op_hit(op_valid_i, op_code_i, SSSR_OP_CLS);
    wire op_ese  = op_hit(op_valid_i, op_code_i, SSSR_OP_ESE);
    wire op_sre  = op_hit(op_valid_i, op_code_i, SSSR_OP_SRE);
    wire op_opc  = op_hit(op_valid_i, op_code_i, SSSR_OP_OPC);
    wire op_opcq = op_hit(op_valid_i, op_code_i, SSSR_OP_OPCQ);
    wire op_sav  = op_hit(op_valid_i, op_code_i, SSSR_OP_SAV);
    wire op_rcl  = op_hit(op_valid_i, op_code_i, SSSR_OP_RCL);
    wire op_rd   = op_hit(op_valid_i, op_code_i, SSSR_OP_DSR_READ);

    // key press edge: event only, never in the condition register
    // the edge is taken after the synchroniser, so a held key counts once
    logic key_d;
    wire  key_rise = key_q & ~key_d;

    // device event register: the key bit is sticky, set beats clear
    // a read and a new press in one cycle keep the press, so no event is
    // lost between one read and the next
    logic [15:0] next_dev_event;
    always_comb begin
        next_dev_event = dev_event_o;
        if (op_rd || op_cls) begin
            next_dev_event = SSSR_RST_STAT;
        end
        if (key_rise) begin
            next_dev_event[SSSR_BIT_KEY] = 1'b1;
        end
    end

    // completion tracking; device clear drops a waiting completion
    // a second completion request while one waits is ignored, so the
    // caller must wait for the reply before asking again
    sssr_state_t state;
    sssr_state_t next_state;
    // done is a level: the caller holds pending_i high while work remains
    wire done = ~pending_i;
    always_comb begin
        next_state = state;
        case (state)
            SSSR_IDLE: begin
                if (op_opc) begin
                    next_state = SSSR_WAIT_FLAG;
                end else if (op_opcq) begin
                    next_state = SSSR_WAIT_REPLY;
                end
            end
            SSSR_WAIT_FLAG: begin
                if (done) begin
                    next_state = SSSR_IDLE;
                end
            end
            SSSR_WAIT_REPLY: begin
                if (done) begin
                    next_state = SSSR_IDLE;
                end
            end
            default: next_state = SSSR_IDLE;
        endcase
        if (dev_clear_i) begin
            next_state = SSSR_IDLE;
        end
    end
    wire opc_fire = state == SSSR_WAIT_FLAG && done && !dev_clear_i;
    wire rep_fire = state == SSSR_WAIT_REPLY && done && !dev_clear_i;

    // standard event register: completion set wins over clear status,
    // so a controller polling the summary cannot miss a completion
    // masks are plain registers: only their own commands write them
    logic [7:0] ese_mask;
    logic [7:0] sre_mask;
    logic [7:0] next_std_event;
    always_comb begin
        next_std_event = op_cls ? SSSR_RST_BYTE : std_event_o;
        if (opc_fire) begin
            next_std_event[SSSR_BIT_OPC] = 1'b1;
        end
    end

    // summary: any enabled event bit gives status byte bit 5
    // the request bit is masked out of its own source, so it can never
    // hold itself on once the summary drops
    wire esb = |(next_std_event & ese_mask);
    wire [7:0] sb_low = {2'b00, esb, 5'b00000};
    wire rqs = |(sb_low & sre_mask & ~(8'h01 << SSSR_BIT_RQS));
    wire [7:0] next_sb = sb_low | ({7'h00, rqs} << SSSR_BIT_RQS);

    // the slot memory has no reset: saved slots outlive a reset, as a
    // non-volatile store would, and cost no reset fan-out
    // configuration store; calibration, zero, address and errors live
    // elsewhere, so only the caller's live settings word is kept here
    logic [CFG_W-1:0] cfg_mem [SLOTS];
    wire slot_ok = op_data_i[3:0] >= SSSR_SLOT_MIN &&
                   op_data_i[3:0] <= SSSR_SLOT_MAX &&
                   op_data_i[7:4] == 4'h0;
    // slot numbers start at one, so the array index is one less; an
    // out-of-range number is refused before it can reach the index
    wire [3:0] slot_idx = op_data_i[3:0] - SSSR_SLOT_MIN;

    always_ff @(posedge clk_sys_i) begin
        if (ce_i && op_sav && slot_ok) begin
            cfg_mem[slot_idx] <= cfg_live_i;
        end
    end

    // status and mask registers; device clear touches none of them but the completion state
    // clock enable low freezes every one of them, masks included
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state         <= SSSR_IDLE;
            key_d         <= 1'b0;
            dev_status_o  <= SSSR_RST_STAT;
            dev_event_o   <= SSSR_RST_STAT;
            std_event_o   <= SSSR_RST_BYTE;
            status_byte_o <= SSSR_RST_BYTE;
            srq_o         <= 1'b0;
            ese_mask      <= SSSR_RST_BYTE;
            sre_mask      <= SSSR_RST_BYTE;
        end else if (ce_i) begin
            state         <= next_state;
            key_d         <= key_q;
            dev_status_o  <= next_cond;
            dev_event_o   <= next_dev_event;
            std_event_o   <= next_std_event;
            status_byte_o <= next_sb;
            srq_o         <= rqs;
            if (op_ese) begin
                ese_mask <= op_data_i;
            end
            if (op_sre) begin
                sre_mask <= op_data_i;
            end
        end
    end

    // output queue holds one reply; device clear flushes it
    // a second query before the read overwrites rather than queues
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reply_data_o  <= SSSR_RST_BYTE;
            reply_valid_o <= 1'b0;
        end else if (ce_i) begin
            if (dev_clear_i) begin
                reply_valid_o <= 1'b0;
            end else if (rep_fire) begin
                reply_data_o  <= SSSR_ASCII_ONE;
                reply_valid_o <= 1'b1;
            end else if (reply_taken_i) begin
                reply_valid_o <= 1'b0;
            end
        end
    end

    // recall, slot errors and the abort pulse
    // recalled data stays put between recalls; only the strobe pulses
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_recall_o     <= '0;
            cfg_recall_vld_o <= 1'b0;
            slot_err_o       <= 1'b0;
            abort_o          <= 1'b0;
        end else if (ce_i) begin
            cfg_recall_vld_o <= op_rcl && slot_ok;
            if (op_rcl && slot_ok) begin
                cfg_recall_o <= cfg_mem[slot_idx];
            end
            slot_err_o <= (op_sav || op_rcl) && !slot_ok;
            // abort tells measuring and trigger logic to return to idle
            abort_o <= dev_clear_i;
        end
    end
endmodule
`default_nettype wire

//--- core/sssr_pkg.sv
// package: constants and types for the sensor status and sync register block
package sssr_pkg;
    // device status bit positions
    localparam int SSSR_BIT_A_CONN   = 1;
    localparam int SSSR_BIT_B_CONN   = 2;
    localparam int SSSR_BIT_A_ERR    = 3;
    localparam int SSSR_BIT_B_ERR    = 4;
    localparam int SSSR_BIT_A_REAR   = 5;
    localparam int SSSR_BIT_B_REAR   = 6;
    localparam int SSSR_BIT_KEY      = 14;
    // standard event and status byte bit positions
    localparam int SSSR_BIT_OPC      = 0;
    localparam int SSSR_BIT_ESB      = 5;
    localparam int SSSR_BIT_RQS      = 6;
    // reply character for the completion query
    localparam logic [7:0] SSSR_ASCII_ONE = 8'h31;
    // configuration slots
    localparam logic [3:0] SSSR_SLOT_MIN  = 4'h1;
    localparam logic [3:0] SSSR_SLOT_MAX  = 4'hA;
    // reset values
    localparam logic [15:0] SSSR_RST_STAT = 16'h0000;
    localparam logic [7:0]  SSSR_RST_BYTE = 8'h00;
    // operations the command decoder hands to this block
    typedef enum logic [3:0] {
        SSSR_OP_NONE,
        SSSR_OP_CLS,
        SSSR_OP_ESE,
        SSSR_OP_SRE,
        SSSR_OP_OPC,
        SSSR_OP_OPCQ,
        SSSR_OP_SAV,
        SSSR_OP_RCL,
        SSSR_OP_DSR_READ
    } sssr_op_t;
    // completion tracking state
    typedef enum logic [1:0] {
        SSSR_IDLE,
        SSSR_WAIT_FLAG,
        SSSR_WAIT_REPLY
    } sssr_state_t;
endpackage

//--- tb/sssr_regs_properties.sv
// checker: port-level properties of the status and sync register block
`timescale 1ns/10ps
`default_nettype none
module sssr_regs_properties
    import sssr_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        op_valid_i,
    input  wire logic [3:0]  op_code_i,
    input  wire logic [7:0]  op_data_i,
    input  wire logic        reply_taken_i,
    input  wire logic        dev_clear_i,
    input  wire logic [15:0] dev_status_o,
    input  wire logic [15:0] dev_event_o,
    input  wire logic [7:0]  std_event_o,
    input  wire logic [7:0]  status_byte_o,
    input  wire logic        srq_o,
    input  wire logic [7:0]  reply_data_o,
    input  wire logic        reply_valid_o,
    input  wire logic        slot_err_o,
    input  wire logic        abort_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // store or recall request, and whether its slot is out of range
    wire logic slot_op = op_valid_i && ce_i &&
        (op_code_i == SSSR_OP_SAV || op_code_i == SSSR_OP_RCL);
    wire logic slot_bad = op_data_i < SSSR_SLOT_MIN ||
                          op_data_i > SSSR_SLOT_MAX;
    wire logic clr_go = dev_clear_i && ce_i;

    unused_bits_a: assert property (
        dev_status_o[15:7] == 9'h000 && !dev_status_o[0])
        else $error("unused status bit set");
    key_event_only_a: assert property (
        dev_event_o[13:0] == 14'h0000 && !dev_event_o[15])
        else $error("stray device event bit");
    reply_char_a: assert property (
        reply_valid_o |-> reply_data_o == SSSR_ASCII_ONE)
        else $error("reply byte wrong");
    reply_holds_a: assert property (
        reply_valid_o && ce_i && !reply_taken_i && !dev_clear_i
        |=> reply_valid_o)
        else $error("reply dropped early");
    clear_abort_a: assert property (
        clr_go |=> abort_o ##1 !abort_o)
        else $error("abort pulse wrong");
    clear_flush_a: assert property (
        clr_go |=> !reply_valid_o)
        else $error("reply not flushed");
    clear_keeps_a: assert property (
        clr_go && !op_valid_i
        |=> $stable(std_event_o) && $stable(status_byte_o))
        else $error("status changed by clear");
    bad_slot_a: assert property (
        slot_op && slot_bad |=> slot_err_o)
        else $error("bad slot not refused");
    good_slot_a: assert property (
        slot_op && !slot_bad |=> !slot_err_o)
        else $error("good slot refused");
    request_level_a: assert property (
        srq_o == status_byte_o[SSSR_BIT_RQS] &&
        (!srq_o || status_byte_o[SSSR_BIT_ESB]))
        else $error("request level mismatch");
    summary_source_a: assert property (
        status_byte_o[SSSR_BIT_ESB] |-> std_event_o != 8'h00)
        else $error("summary without event");
endmodule
bind sssr_regs sssr_regs_properties CHK (.*);
`default_nettype wire

//--- tb/sssr_ctrl_model.sv
// partner: remote bus controller driving the command port
`timescale 1ns/10ps
`default_nettype none
module sssr_ctrl_model
    import sssr_pkg::*;
(
    input  wire logic  clk_sys_i,
    output logic       op_valid_o,
    output logic [3:0] op_code_o,
    output logic [7:0] op_data_o,
    output logic       reply_taken_o,
    output logic       dev_clear_o
);
    // idle port at start
    initial begin
        {op_valid_o, reply_taken_o, dev_clear_o, op_data_o} = '0;
        op_code_o = SSSR_OP_NONE;
    end
    // one command for one cycle; released data is inverted so it never
    // looks valid by accident; the bench sequences calls
    task automatic send(input sssr_op_t op, input logic [7:0] d);
        @(posedge clk_sys_i);
        #1;
        op_valid_o = 1'b1;
        op_code_o  = op;
        op_data_o  = d;
        @(posedge clk_sys_i);
        #1;
        op_valid_o = 1'b0;
        op_code_o  = SSSR_OP_NONE;
        op_data_o  = ~d;
    endtask
    // reply consumed or device clear, each a one-cycle pulse
    task automatic pulse(input bit clr);
        @(posedge clk_sys_i);
        #1;
        if (clr) dev_clear_o = 1'b1;
        else reply_taken_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        {dev_clear_o, reply_taken_o} = 2'b00;
    endtask
endmodule
`default_nettype wire

//--- tb/sssr_regs_bench.sv
// testbench: sensor status, completion sync, slots and device clear
`timescale 1ns/10ps
`default_nettype none
module sssr_regs_bench
    import sssr_pkg::*;
;
    logic        clk_sys_i, rst_n_i, ce_i, key, pending;
    logic [5:0]  pins; // b_mem a_mem b_rear b_front a_rear a_front
    logic [31:0] cfg_live;
    wire logic   op_valid, reply_taken, dev_clear, srq, reply_valid;
    wire logic   recall_vld, slot_err, abort;
    wire logic [3:0]  op_code;
    wire logic [7:0]  op_data, std_ev, sbyte, reply_data;
    wire logic [15:0] dstat, devent;
    wire logic [31:0] recall;
    int          miscompares, compares;
    localparam logic [5:0]  PIN_T [8] = '{6'h01, 6'h02, 6'h03, 6'h11,
                                          6'h04, 6'h08, 6'h0C, 6'h24};
    localparam logic [15:0] EXP_T [8] = '{16'h0002, 16'h0022, 16'h002A,
        16'h000A, 16'h0004, 16'h0044, 16'h0054, 16'h0014};

    sssr_regs DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .a_front_i(pins[0]), .a_rear_i(pins[1]), .b_front_i(pins[2]),
        .b_rear_i(pins[3]), .a_mem_fail_i(pins[4]), .b_mem_fail_i(pins[5]),
        .key_press_i(key), .op_valid_i(op_valid), .op_code_i(op_code),
        .op_data_i(op_data), .pending_i(pending), .cfg_live_i(cfg_live),
        .reply_taken_i(reply_taken), .dev_clear_i(dev_clear),
        .dev_status_o(dstat), .dev_event_o(devent), .std_event_o(std_ev),
        .status_byte_o(sbyte), .srq_o(srq), .reply_data_o(reply_data),
        .reply_valid_o(reply_valid), .cfg_recall_o(recall),
        .cfg_recall_vld_o(recall_vld), .slot_err_o(slot_err),
        .abort_o(abort));
    sssr_ctrl_model CTRL (.clk_sys_i(clk_sys_i), .op_valid_o(op_valid),
        .op_code_o(op_code), .op_data_o(op_data),
        .reply_taken_o(reply_taken), .dev_clear_o(dev_clear));

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    // 0 reply, 1 recall, 2 slot error, 3 completion event
    function automatic logic sel(input int k);
        return k == 0 ? reply_valid : k == 1 ? recall_vld :
               k == 2 ? slot_err : std_ev[0];
    endfunction
    // bounded wait; running out counts as a mismatch and ends the run
    task automatic wait_hi(input int k);
        int n;
        n = 0;
        while (sel(k) !== 1'b1) begin
            n++;
            if (n > 20) begin
                miscompares++;
                summarize();
            end
            cyc(1);
        end
    endtask

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        {rst_n_i, key, pending, pins, cfg_live, miscompares, compares} = '0;
        ce_i = 1'b1;
        cyc(5);
        rst_n_i = 1'b1;
        cyc(1);
        check("reset", 32'h0, {dstat, std_ev, sbyte});
        for (int i = 0; i < 8; i++) begin
            pins = PIN_T[i];
            cyc(8);
            check("status", EXP_T[i], dstat);
        end
        // clock enable low must freeze the synchronisers and registers
        ce_i = 1'b0;
        pins = PIN_T[1];
        cyc(8);
        check("frozen", EXP_T[7], dstat);
        ce_i = 1'b1;
        cyc(8);
        check("thawed", EXP_T[1], dstat);
        pins = 6'h00;
        key = 1'b1;
        cyc(8);
        check("key event", 16'h4000, {devent});
        key = 1'b0;
        CTRL.send(SSSR_OP_DSR_READ, 8'h00);
        cyc(1);
        check("event read", 16'h0000, devent);
        CTRL.pulse(1'b1);
        CTRL.send(SSSR_OP_CLS, 8'h00);
        CTRL.send(SSSR_OP_ESE, 8'h01);
        CTRL.send(SSSR_OP_SRE, 8'h20);
        pending = 1'b1;
        CTRL.send(SSSR_OP_OPCQ, 8'h00);
        cyc(4);
        check("early reply", 1'b0, reply_valid);
        pending = 1'b0;
        wait_hi(0);
        check("reply", SSSR_ASCII_ONE, reply_data);
        CTRL.pulse(1'b0);
        pending = 1'b1;
        CTRL.send(SSSR_OP_OPC, 8'h00);
        cyc(4);
        check("early done", 8'h00, std_ev);
        pending = 1'b0;
        wait_hi(3);
        cyc(1);
        check("summary", 9'h160, {srq, sbyte});
        CTRL.send(SSSR_OP_CLS, 8'h00);
        cyc(1);
        check("cleared", 17'h0, {srq, std_ev, sbyte});
        CTRL.send(SSSR_OP_ESE, 8'h00);
        CTRL.send(SSSR_OP_OPC, 8'h00);
        wait_hi(3);
        cyc(1);
        check("masked", 8'h00, sbyte);
        pending = 1'b1;
        CTRL.send(SSSR_OP_OPCQ, 8'h00);
        CTRL.pulse(1'b1);
        check("abort", 1, abort);
        pending = 1'b0;
        cyc(4);
        check("kept", 10'h001, {reply_valid, abort, std_ev});
        for (logic [7:0] s = 8'h01; s <= 8'h0A; s++) begin
            cfg_live = {24'hA5A5A5, s};
            CTRL.send(SSSR_OP_SAV, s);
        end
        cfg_live = 32'h0000_0000;
        foreach (PIN_T[i]) begin
            CTRL.send(i[0] ? SSSR_OP_RCL : SSSR_OP_SAV, i[1] ? 8'h0B : 8'h00);
            wait_hi(2);
            check("slot error", 1'b1, slot_err);
        end
        for (logic [7:0] s = 8'h01; s <= 8'h0A; s++) begin
            CTRL.send(SSSR_OP_RCL, s);
            wait_hi(1);
            check("recall", {24'hA5A5A5, s}, recall);
        end
        // a second reset mid-run clears events, reply and pulses at once
        rst_n_i = 1'b0;
        cyc(1);
        check("reset again", 0, {devent, reply_data});
        check("pulses", 0, {srq, reply_valid, slot_err, abort});
        rst_n_i = 1'b1;
        CTRL.send(SSSR_OP_OPCQ, 8'h00);
        wait_hi(0);
        check("reply after reset", SSSR_ASCII_ONE, reply_data);
        summarize();
    end
endmodule
`default_nettype wire
